// [logic/branch_prediction_unit.sv]
// Branch prediction unit: target buffer, direction counters, return stack
// Assumes fetch, resolve and eviction inputs come from CORE_CLK logic
`timescale 1ns/100ps
`default_nettype none
module branch_prediction_unit
   import bpu_pkg::*;
(
   // Clock and reset
   input  wire logic      CORE_CLK,
   input  wire logic      RSTN,
   // Fetch side
   input  wire fetch_t    FETCH,
   output var  redirect_t REDIRECT,
   output var  line_req_t LINE_REQ,
   output var  logic      FETCH_HOLD,
   // Branch resolution
   input  wire resolve_t  RESOLVE,
   // Line eviction to second level
   input  wire evict_t    EVICT,
   output var  evict_t    L2_WRITE
);

   //---------------------------------------------------------------
   // Reset release
   //---------------------------------------------------------------
   logic rst_s1_r;
   logic rst_n_r;

   always_ff @(posedge CORE_CLK or negedge RSTN) begin
      if (!RSTN) begin
         rst_s1_r <= 1'b0;
         rst_n_r  <= 1'b0;
      end else begin
         rst_s1_r <= 1'b1;
         rst_n_r  <= rst_s1_r;
      end
   end

   //---------------------------------------------------------------
   // Declarations
   //---------------------------------------------------------------
   fstate_t                 state_r;
   logic [PEN_W-1:0]        pen_cnt_r;
   logic [ADDR_W-1:0]       fix_addr_r;
   logic [HIST_W-1:0]       ghr_r;
   logic                    misp;
   logic                    fetch_ok;
   logic                    restart;
   logic [TBUF_IDX_W-1:0]   rd_ti;
   logic [TBUF_IDX_W-1:0]   wr_ti;
   logic                    tbuf_wr;
   logic                    tbuf_hit;
   logic [ADDR_W-1:0]       tbuf_tgt;
   logic                    dir_taken;
   logic                    dir_upd;
   logic                    rstk_valid;
   logic [ADDR_W-1:0]       rstk_top;
   logic                    pred_taken;
   logic                    pred_rstk;
   logic [ADDR_W-1:0]       pred_addr;
   logic [TBUF_ENTRIES-1:0] tbuf_vld_r;
   logic [TAG_W-1:0]        tbuf_tag_r [TBUF_ENTRIES];
   logic [ADDR_W-1:0]       tbuf_tgt_r [TBUF_ENTRIES];

   assign misp     = RESOLVE.valid && RESOLVE.mispredict;
   // Lookup runs on the very fetch the cache sees
   assign fetch_ok = FETCH.valid && state_r == ST_RUN && !misp;
   assign restart  = state_r == ST_HOLD && pen_cnt_r == '0 && !misp;

   //---------------------------------------------------------------
   // Mispredict recovery
   //---------------------------------------------------------------
   always_ff @(posedge CORE_CLK or negedge rst_n_r) begin
      if (!rst_n_r) begin
         state_r    <= ST_RUN;
         pen_cnt_r  <= '0;
         fix_addr_r <= '0;
         FETCH_HOLD <= 1'b0;
      end else if (misp) begin
         state_r    <= ST_HOLD;
         pen_cnt_r  <= PEN_LOAD;
         fix_addr_r <= RESOLVE.correct_addr;
         FETCH_HOLD <= 1'b1;
      end else begin
         unique case (state_r)
            ST_RUN: begin
               FETCH_HOLD <= 1'b0;
            end
            ST_HOLD: begin
               if (pen_cnt_r == '0) begin
                  state_r    <= ST_RUN;
                  FETCH_HOLD <= 1'b0;
               end else begin
                  pen_cnt_r <= pen_cnt_r - 1'b1;
               end
            end
         endcase
      end
   end

   //---------------------------------------------------------------
   // Global history
   //---------------------------------------------------------------
   always_ff @(posedge CORE_CLK or negedge rst_n_r) begin
      if (!rst_n_r) begin
         ghr_r <= GHR_RST;
      end else if (RESOLVE.valid && RESOLVE.kind == BR_COND) begin
         ghr_r <= {ghr_r[HIST_W-2:0], RESOLVE.taken};
      end
   end

   //---------------------------------------------------------------
   // Target buffer
   //---------------------------------------------------------------
   assign rd_ti    = tbuf_idx(FETCH.br_addr);
   assign wr_ti    = tbuf_idx(RESOLVE.br_addr);
   assign tbuf_wr  = RESOLVE.valid && RESOLVE.taken;
   assign tbuf_tgt = tbuf_tgt_r[rd_ti];
   assign tbuf_hit = tbuf_vld_r[rd_ti] &&
                     tbuf_tag_r[rd_ti] == tbuf_tag(FETCH.br_addr);

   always_ff @(posedge CORE_CLK or negedge rst_n_r) begin
      if (!rst_n_r) begin
         tbuf_vld_r <= '0;
      end else if (tbuf_wr) begin
         tbuf_vld_r[wr_ti] <= 1'b1;
      end
   end

   always_ff @(posedge CORE_CLK) begin
      if (tbuf_wr) begin
         tbuf_tag_r[wr_ti] <= tbuf_tag(RESOLVE.br_addr);
         tbuf_tgt_r[wr_ti] <= RESOLVE.target;
      end
   end

   //---------------------------------------------------------------
   // Direction counters and return stack
   //---------------------------------------------------------------
   assign dir_upd = RESOLVE.valid && RESOLVE.kind == BR_COND;

   global_history_counter_table #(
      .ENTRIES (DIR_ENTRIES)
   ) u_dir (
      .clk       (CORE_CLK),
      .rst_n     (rst_n_r),
      .rd_idx    (dir_idx(ghr_r, FETCH.br_addr)),
      .rd_taken  (dir_taken),
      .upd_en    (dir_upd),
      .upd_idx   (dir_idx(ghr_r, RESOLVE.br_addr)),
      .upd_taken (RESOLVE.taken)
   );

   return_stack #(
      .DEPTH (RSTK_DEPTH),
      .W     (ADDR_W)
   ) u_rstk (
      .clk       (CORE_CLK),
      .rst_n     (rst_n_r),
      .push      (fetch_ok && FETCH.kind == BR_CALL),
      .push_addr (FETCH.next_ip),
      .pop       (fetch_ok && FETCH.kind == BR_RET),
      .top_addr  (rstk_top),
      .top_valid (rstk_valid)
   );

   //---------------------------------------------------------------
   // Prediction
   //---------------------------------------------------------------
   always_comb begin
      pred_taken = 1'b0;
      pred_rstk  = 1'b0;
      pred_addr  = tbuf_tgt;
      unique case (FETCH.kind)
         BR_NONE: begin
            pred_taken = 1'b0;
         end
         BR_COND: begin
            pred_taken = tbuf_hit && dir_taken;
         end
         BR_JUMP, BR_CALL: begin
            pred_taken = tbuf_hit;
         end
         BR_RET: begin
            if (rstk_valid) begin
               pred_taken = 1'b1;
               pred_rstk  = 1'b1;
               pred_addr  = rstk_top;
            end else begin
               pred_taken = tbuf_hit;
            end
         end
         default: begin
            pred_taken = 1'b0;
         end
      endcase
   end

   //---------------------------------------------------------------
   // Fetch redirect and line requests
   //---------------------------------------------------------------
   always_ff @(posedge CORE_CLK or negedge rst_n_r) begin
      if (!rst_n_r) begin
         REDIRECT <= '0;
      end else if (restart) begin
         REDIRECT.valid     <= 1'b1;
         REDIRECT.taken     <= 1'b0;
         REDIRECT.tbuf_hit  <= 1'b0;
         REDIRECT.rstk_used <= 1'b0;
         REDIRECT.addr      <= fix_addr_r;
      end else begin
         REDIRECT.valid     <= fetch_ok && pred_taken;
         REDIRECT.taken     <= fetch_ok && pred_taken;
         REDIRECT.tbuf_hit  <= fetch_ok && tbuf_hit;
         REDIRECT.rstk_used <= fetch_ok && pred_rstk;
         REDIRECT.addr      <= pred_addr;
      end
   end

   always_ff @(posedge CORE_CLK or negedge rst_n_r) begin
      if (!rst_n_r) begin
         LINE_REQ <= '0;
      end else begin
         LINE_REQ.valid     <= fetch_ok;
         LINE_REQ.line      <= line_of(FETCH.addr);
         LINE_REQ.next_line <= line_of(FETCH.addr) + 1'b1;
      end
   end

   // Selector and predecode bits leave with the line bytes
   always_ff @(posedge CORE_CLK or negedge rst_n_r) begin
      if (!rst_n_r) begin
         L2_WRITE <= '0;
      end else begin
         L2_WRITE <= EVICT;
      end
   end

   //---------------------------------------------------------------
   // Checks
   //---------------------------------------------------------------
   default clocking cb @(posedge CORE_CLK);
   endclocking
   default disable iff (!rst_n_r);

   property p_lookup;
      fetch_ok |=> LINE_REQ.valid && REDIRECT.valid == $past(pred_taken);
   endproperty
   a_lookup: assert property (p_lookup)
      else $error("prediction not alongside line request");

   property p_evict;
      EVICT.valid |=> L2_WRITE.valid && L2_WRITE == $past(EVICT);
   endproperty
   a_evict: assert property (p_evict)
      else $error("eviction lost selector or predecode bits");

   property p_taken;
      fetch_ok && FETCH.kind == BR_JUMP && tbuf_hit
      |=> REDIRECT.valid && REDIRECT.addr == $past(tbuf_tgt);
   endproperty
   a_taken: assert property (p_taken)
      else $error("taken jump not redirected next cycle");

   property p_hold;
      misp |=> FETCH_HOLD[*8] ##1 FETCH_HOLD ##1 FETCH_HOLD;
   endproperty
   a_hold: assert property (p_hold)
      else $error("fetch resumed within ten cycles");

   property p_restart;
      misp ##1 (!misp)[*8] ##1 !misp ##1 !misp
      |=> REDIRECT.valid && !FETCH_HOLD && REDIRECT.addr == fix_addr_r;
   endproperty
   a_restart: assert property (p_restart)
      else $error("no restart at correct path");

   property p_fill;
      RESOLVE.valid && RESOLVE.taken && RESOLVE.kind == BR_JUMP
      ##1 !RESOLVE.valid
      ##1 fetch_ok && FETCH.kind == BR_JUMP &&
          FETCH.br_addr == $past(RESOLVE.br_addr, 2)
      |=> REDIRECT.valid && REDIRECT.addr == $past(RESOLVE.target, 3);
   endproperty
   a_fill: assert property (p_fill)
      else $error("stored target not supplied");

   property p_hist;
      RESOLVE.valid && RESOLVE.kind == BR_COND
      |=> ghr_r == {$past(ghr_r[HIST_W-2:0]), $past(RESOLVE.taken)};
   endproperty
   a_hist: assert property (p_hist)
      else $error("history not shifted");

   property p_ret;
      fetch_ok && FETCH.kind == BR_RET && rstk_valid
      |=> REDIRECT.rstk_used && REDIRECT.addr == $past(rstk_top);
   endproperty
   a_ret: assert property (p_ret)
      else $error("return not predicted from stack");

   property p_empty;
      fetch_ok && FETCH.kind == BR_RET && !rstk_valid
      |=> !REDIRECT.rstk_used && REDIRECT.valid == $past(tbuf_hit);
   endproperty
   a_empty: assert property (p_empty)
      else $error("empty stack did not fall back");

   property p_line;
      fetch_ok |=> LINE_REQ.line == $past(FETCH.addr[ADDR_W-1:LINE_LSB])
                   && LINE_REQ.next_line == LINE_REQ.line + 1'b1;
   endproperty
   a_line: assert property (p_line)
      else $error("line or next line wrong");

   c_restart: cover property (misp ##[10:12] REDIRECT.valid);
   c_ret: cover property (fetch_ok && FETCH.kind == BR_RET && rstk_valid);
   c_jump: cover property (fetch_ok && FETCH.kind == BR_JUMP && tbuf_hit);

endmodule
`default_nettype wire

// [inc/bpu_pkg.sv]
// Constants, types and helpers for the branch prediction unit
// Assumes a single core clock; every user imports the whole package
package bpu_pkg;

   //---------------------------------------------------------------
   // Sizes
   //---------------------------------------------------------------
   localparam int ADDR_W      = 32;
   localparam int LINE_LSB    = 6;
   localparam int LN_W        = ADDR_W - LINE_LSB;
   localparam int LINE_BITS   = 512;
   localparam int SEL_W       = 16;
   localparam int PDC_W       = 64;
   localparam int TBUF_ENTRIES = 2048;
   localparam int TBUF_IDX_W  = $clog2(TBUF_ENTRIES);
   localparam int TAG_W       = 8;
   localparam int DIR_ENTRIES = 16384;
   localparam int HIST_W      = 8;
   localparam int RSTK_DEPTH  = 12;

   //---------------------------------------------------------------
   // Reset values and counts
   //---------------------------------------------------------------
   localparam int MISP_PENALTY_CYC = 10;
   localparam int PEN_W = 4;
   localparam logic [PEN_W-1:0] PEN_LOAD = PEN_W'(MISP_PENALTY_CYC - 1);
   localparam logic [1:0] CNT_RST = 2'h1;
   localparam logic [1:0] CNT_MAX = 2'h3;
   localparam logic [1:0] CNT_MIN = 2'h0;
   localparam logic [HIST_W-1:0] GHR_RST = 8'h00;

   //---------------------------------------------------------------
   // Types
   //---------------------------------------------------------------
   typedef enum logic [2:0] {
      BR_NONE = 3'h0,
      BR_COND = 3'h1,
      BR_CALL = 3'h2,
      BR_JUMP = 3'h3,
      BR_RET  = 3'h6
   } br_kind_t;

   typedef enum logic {
      ST_RUN  = 1'b0,
      ST_HOLD = 1'b1
   } fstate_t;

   typedef struct packed {
      logic              valid;
      logic [ADDR_W-1:0] addr;
      br_kind_t          kind;
      logic [ADDR_W-1:0] br_addr;
      logic [ADDR_W-1:0] next_ip;
   } fetch_t;

   typedef struct packed {
      logic              valid;
      logic              mispredict;
      br_kind_t          kind;
      logic              taken;
      logic [ADDR_W-1:0] br_addr;
      logic [ADDR_W-1:0] target;
      logic [ADDR_W-1:0] correct_addr;
   } resolve_t;

   typedef struct packed {
      logic              valid;
      logic              taken;
      logic              tbuf_hit;
      logic              rstk_used;
      logic [ADDR_W-1:0] addr;
   } redirect_t;

   typedef struct packed {
      logic            valid;
      logic [LN_W-1:0] line;
      logic [LN_W-1:0] next_line;
   } line_req_t;

   typedef struct packed {
      logic                 valid;
      logic [LN_W-1:0]      line;
      logic [LINE_BITS-1:0] data;
      logic [SEL_W-1:0]     sel;
      logic [PDC_W-1:0]     predec;
   } evict_t;

   //---------------------------------------------------------------
   // Index helpers
   //---------------------------------------------------------------
   function automatic logic [TBUF_IDX_W-1:0] tbuf_idx(
      input logic [ADDR_W-1:0] a);
      return a[TBUF_IDX_W:1];
   endfunction

   function automatic logic [TAG_W-1:0] tbuf_tag(
      input logic [ADDR_W-1:0] a);
      return a[TBUF_IDX_W+TAG_W:TBUF_IDX_W+1];
   endfunction

   // History in the middle, address bits 4:1 low, 6:5 on top
   function automatic logic [13:0] dir_idx(
      input logic [HIST_W-1:0] h,
      input logic [ADDR_W-1:0] a);
      return {a[6:5], h, a[4:1]};
   endfunction

   function automatic logic [LN_W-1:0] line_of(
      input logic [ADDR_W-1:0] a);
      return a[ADDR_W-1:LINE_LSB];
   endfunction

endpackage

// [logic/global_history_counter_table.sv]
// Table of two-bit saturating direction counters
// Assumes read index and update port from logic on the same clock
`timescale 1ns/100ps
`default_nettype none
module global_history_counter_table
   import bpu_pkg::*;
#(
   parameter int ENTRIES = DIR_ENTRIES,
   parameter int IDX_W   = $clog2(ENTRIES)
) (
   // Clock and reset
   input  wire logic             clk,
   input  wire logic             rst_n,
   // Lookup
   input  wire logic [IDX_W-1:0] rd_idx,
   output logic                  rd_taken,
   // Update
   input  wire logic             upd_en,
   input  wire logic [IDX_W-1:0] upd_idx,
   input  wire logic             upd_taken
);

   logic [1:0] cnt_r [ENTRIES];

   assign rd_taken = cnt_r[rd_idx][1];

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < ENTRIES; i++) begin
            cnt_r[i] <= CNT_RST;
         end
      end else if (upd_en) begin
         if (upd_taken && cnt_r[upd_idx] != CNT_MAX) begin
            cnt_r[upd_idx] <= cnt_r[upd_idx] + 2'h1;
         end else if (!upd_taken && cnt_r[upd_idx] != CNT_MIN) begin
            cnt_r[upd_idx] <= cnt_r[upd_idx] - 2'h1;
         end
      end
   end

   property p_sat_top;
      @(posedge clk) disable iff (!rst_n)
      upd_en && upd_taken && cnt_r[upd_idx] == CNT_MAX
      |=> cnt_r[$past(upd_idx)] == CNT_MAX;
   endproperty
   a_sat_top: assert property (p_sat_top)
      else $error("counter passed upper end");

   property p_sat_bot;
      @(posedge clk) disable iff (!rst_n)
      upd_en && !upd_taken && cnt_r[upd_idx] == CNT_MIN
      |=> cnt_r[$past(upd_idx)] == CNT_MIN;
   endproperty
   a_sat_bot: assert property (p_sat_bot)
      else $error("counter passed lower end");

endmodule
`default_nettype wire

// [logic/return_stack.sv]
// Circular return address stack
// Assumes push and pop never in the same cycle
`timescale 1ns/100ps
`default_nettype none
module return_stack
   import bpu_pkg::*;
#(
   parameter int DEPTH = RSTK_DEPTH,
   parameter int W     = ADDR_W
) (
   // Clock and reset
   input  wire logic         clk,
   input  wire logic         rst_n,
   // Stack operations
   input  wire logic         push,
   input  wire logic [W-1:0] push_addr,
   input  wire logic         pop,
   output logic [W-1:0]      top_addr,
   output logic              top_valid
);

   localparam int PW = $clog2(DEPTH);
   localparam logic [PW:0] FULL = (PW+1)'(DEPTH);

   logic [W-1:0]  mem_r [DEPTH];
   logic [PW-1:0] top_r;
   logic [PW:0]   cnt_r;

   function automatic logic [PW-1:0] wrap_inc(input logic [PW-1:0] p);
      return (p == PW'(DEPTH - 1)) ? '0 : p + 1'b1;
   endfunction

   assign top_addr  = mem_r[top_r];
   assign top_valid = cnt_r != '0;

   // Count saturates so the oldest slot is reused when full
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         top_r <= '0;
         cnt_r <= '0;
      end else if (push) begin
         top_r <= wrap_inc(top_r);
         if (cnt_r != FULL) begin
            cnt_r <= cnt_r + 1'b1;
         end
      end else if (pop && top_valid) begin
         top_r <= (top_r == '0) ? PW'(DEPTH - 1) : top_r - 1'b1;
         cnt_r <= cnt_r - 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (push) begin
         mem_r[wrap_inc(top_r)] <= push_addr;
      end
   end

   property p_push_pop;
      @(posedge clk) disable iff (!rst_n)
      push ##1 (!push && !pop) ##1 (pop && !push)
      |-> top_valid && top_addr == $past(push_addr, 2);
   endproperty
   a_push_pop: assert property (p_push_pop)
      else $error("pop did not return last pushed address");

   property p_full;
      @(posedge clk) disable iff (!rst_n)
      push && cnt_r == FULL |=> cnt_r == FULL;
   endproperty
   a_full: assert property (p_full)
      else $error("stack depth grew past its size");

endmodule
`default_nettype wire

// [tb/fetch_side_model.sv]
// Fetch logic and cache side model driving the predictor inputs
// Assumes one core clock; the bench calls its tasks hierarchically
`timescale 1ns/100ps
`default_nettype none
module fetch_side_model
   import bpu_pkg::*;
(
   // Clock and penalty level
   input  wire logic clk,
   input  wire logic hold,
   // Requests towards the predictor
   output var fetch_t   fetch,
   output var resolve_t resolve,
   output var evict_t   evict
);
   initial begin
      fetch = '0;
      resolve = '0;
      evict = '0;
   end
   // Waits out the penalty unless told to push through
   task automatic do_fetch(input fetch_t f, input bit obey);
      int n;
      n = 0;
      while (obey && hold !== 1'b0 && n < 40) begin
         @(posedge clk);
         #1;
         n++;
      end
      @(posedge clk);
      fetch <= f;
      @(posedge clk);
      fetch <= '0;
   endtask
   task automatic do_resolve(input resolve_t r);
      @(posedge clk);
      resolve <= r;
      @(posedge clk);
      resolve <= '0;
   endtask
   // Whole line with selectors and predecode in one beat
   task automatic do_evict(input evict_t e);
      @(posedge clk);
      evict <= e;
      @(posedge clk);
      evict <= '0;
   endtask
endmodule
`default_nettype wire

// [tb/branch_prediction_unit_bench.sv]
// Self-checking bench for the branch prediction unit
// Assumes the package and design files are compiled first
`timescale 1ns/100ps
`default_nettype none
module branch_prediction_unit_bench
   import bpu_pkg::*;
;
   logic        CORE_CLK = 1'b0;
   logic        RSTN = 1'b0;
   fetch_t      fetch;
   resolve_t    resolve;
   evict_t      evict;
   redirect_t   REDIRECT;
   line_req_t   LINE_REQ;
   logic        FETCH_HOLD;
   evict_t      L2_WRITE;
   int          seed = 32'h680e;
   int          n_errors = 0;
   int          compares = 0;
   int          cnt [DIR_ENTRIES];
   logic [7:0]  hist = 8'h00;
   logic [7:0]  btag [int];
   logic [31:0] btgt [int];
   logic [31:0] rs [$];

   always #5 CORE_CLK = ~CORE_CLK;

   branch_prediction_unit i_dut (
      .CORE_CLK (CORE_CLK), .RSTN (RSTN), .FETCH (fetch),
      .REDIRECT (REDIRECT), .LINE_REQ (LINE_REQ),
      .FETCH_HOLD (FETCH_HOLD), .RESOLVE (resolve), .EVICT (evict),
      .L2_WRITE (L2_WRITE));
   fetch_side_model i_far (
      .clk (CORE_CLK), .hold (FETCH_HOLD), .fetch (fetch),
      .resolve (resolve), .evict (evict));

   //--------------------------------------------------------------
   // Reference model and compare
   //--------------------------------------------------------------
   task automatic check(input logic [63:0] s, e, input string m);
      compares++;
      if (s !== e) begin
         n_errors++;
         $display("[ERR] %0t %s", $time, m);
      end
   endtask
   function automatic int didx(input logic [31:0] b);
      return {b[6:5], hist, b[4:1]};
   endfunction
   task automatic res(input br_kind_t k, input bit tk,
      input logic [31:0] b, t, input bit mp, input logic [31:0] c);
      int i;
      i = didx(b);
      if (tk) begin
         btag[b[11:1]] = b[19:12];
         btgt[b[11:1]] = t;
      end
      if (k == BR_COND) begin
         if (tk && cnt[i] < 3)
            cnt[i]++;
         else if (!tk && cnt[i] > 0)
            cnt[i]--;
         hist = {hist[6:0], tk};
      end
      i_far.do_resolve('{1'b1, mp, k, tk, b, t, c});
   endtask
   task automatic fet(input br_kind_t k, input logic [31:0] b, n);
      fetch_t f;
      int i;
      bit tk;
      bit ru;
      bit h;
      logic [31:0] t;
      f = '{1'b1, $random(seed), k, b, n};
      i = b[11:1];
      t = 32'h0;
      tk = 1'b0;
      ru = 1'b0;
      h = btag.exists(i) && btag[i] == b[19:12];
      if (h) begin
         tk = k != BR_NONE && (k != BR_COND || cnt[didx(b)] > 1);
         t = btgt[i];
      end
      if (k == BR_CALL) begin
         rs.push_back(n);
         if (rs.size() > RSTK_DEPTH)
            void'(rs.pop_front());
      end
      if (k == BR_RET && rs.size() > 0) begin
         tk = 1'b1;
         ru = 1'b1;
         t = rs.pop_back();
      end
      i_far.do_fetch(f, 1'b1);
      #1;
      check({REDIRECT.valid, REDIRECT.tbuf_hit}, {tk, h},
         "redirect valid");
      if (tk)
         check({REDIRECT.taken, REDIRECT.rstk_used, REDIRECT.addr},
            {1'b1, ru, t}, "redirect target");
      check({LINE_REQ.valid, LINE_REQ.line, LINE_REQ.next_line},
         {1'b1, f.addr[31:6], f.addr[31:6] + 26'h1}, "line");
   endtask

   //--------------------------------------------------------------
   // Run sequence
   //--------------------------------------------------------------
   task automatic report_and_stop();
      $display("errors %0d compares %0d", n_errors, compares);
      if (n_errors == 0 && compares > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   initial begin
      #100000;
      n_errors++;
      report_and_stop();
   end
   initial begin
      evict_t e;
      logic [31:0] r;
      foreach (cnt[i])
         cnt[i] = CNT_RST;
      repeat (4) @(posedge CORE_CLK);
      RSTN <= 1'b1;
      #1;
      check({REDIRECT.valid, LINE_REQ.valid, FETCH_HOLD, L2_WRITE.valid},
         0, "reset");
      repeat (4) @(posedge CORE_CLK);
      for (int j = 0; j < 3; j++) begin
         e = '0;
         e.valid = 1'b1;
         e.line = LN_W'($random(seed));
         e.sel = SEL_W'($random(seed));
         e.predec = {$random(seed), $random(seed)};
         for (int w = 0; w < 16; w++)
            e.data[w*32 +: 32] = $random(seed);
         i_far.do_evict(e);
         #1;
         check(L2_WRITE === e, 1, "evict");
      end
      res(BR_JUMP, 1'b1, 32'h0000_1234, 32'h0000_8840, 1'b0, 32'h0);
      fet(BR_JUMP, 32'h0000_1234, 32'h0);
      fet(BR_JUMP, 32'h0001_1234, 32'h0);
      fet(BR_NONE, 32'h0000_1234, 32'h0);
      // Few addresses, then a not-taken run at one address
      for (int j = 0; j < 60; j++) begin
         r = (j < 48) ? $random(seed) : 32'h0;
         res(BR_COND, |r[10:8], 32'h2200 | (r & 32'h62), 32'h4000,
            1'b0, 32'h0);
         fet(BR_COND, 32'h2200 | (r & 32'h62), 32'h0);
      end
      // Buffer entry for the return that finds the stack empty
      res(BR_RET, 1'b1, 32'h0009_0000, 32'h0000_7700, 1'b0, 32'h0);
      for (int j = 0; j < 13; j++)
         fet(BR_CALL, 32'h0008_0000 + 32'(8*j),
            32'h1000_0000 + 32'(16*j));
      for (int j = 0; j < 13; j++)
         fet(BR_RET, 32'h0009_0000, 32'h0);
      res(BR_NONE, 1'b0, 32'h0, 32'h0, 1'b1, 32'h0000_5a40);
      #1;
      check(FETCH_HOLD, 1, "hold");
      i_far.do_fetch('{1'b1, 32'h40, BR_NONE, 32'h0, 32'h0}, 1'b0);
      #1;
      check({LINE_REQ.valid, FETCH_HOLD}, 2'b01, "refused");
      repeat (7) @(posedge CORE_CLK);
      #1;
      check(FETCH_HOLD, 1, "hold end");
      @(posedge CORE_CLK);
      #1;
      check({REDIRECT.valid, REDIRECT.taken, REDIRECT.addr, FETCH_HOLD},
         {1'b1, 1'b0, 32'h0000_5a40, 1'b0}, "restart");
      fet(BR_NONE, 32'h0, 32'h0);
      report_and_stop();
   end
endmodule
`default_nettype wire
